// ---- src/wopt_pkg.sv ----
// Constants, register map and types of the wait one-shot PWM timer.
package wopt_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [9:0] IDX_MODE = 10'h120;
  localparam logic [9:0] IDX_CTRL1 = 10'h121;
  localparam logic [9:0] IDX_TRIG = 10'h122;
  localparam logic [9:0] IDX_IEN = 10'h123;
  localparam logic [9:0] IDX_STAT = 10'h124;
  localparam logic [9:0] IDX_IRQC = 10'h125;
  localparam logic [9:0] IDX_CNT = 10'h126;
  localparam logic [9:0] IDX_GRA = 10'h128;
  localparam logic [9:0] IDX_GRB = 10'h129;
  localparam logic [9:0] IDX_GRC = 10'h12a;
  localparam logic [9:0] IDX_GRD = 10'h12b;
  // Mode register fields.
  localparam int MODE_RUN = 0;
  localparam int MODE_BFD = 1;
  // Output and clock control fields.
  localparam int C1_OUTB = 1;
  localparam int C1_CKLO = 4;
  localparam int C1_CKHI = 6;
  localparam int C1_CLEAR_ON_PERIOD_SEL = 7;
  localparam logic [7:0] C1_RST = 8'h00;
  // Trigger control fields.
  localparam int TRG_EDLO = 0;
  localparam int TRG_EDHI = 1;
  localparam int TRG_STOP = 2;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  // Status bits: compare A, B, C, D and overflow.
  localparam int ST_A = 0;
  localparam int ST_B = 1;
  localparam int ST_C = 2;
  localparam int ST_D = 3;
  localparam int ST_OVF = 4;
  localparam int NSRC = 5;
  // Count source codes.
  localparam logic [2:0] CK_F1 = 3'h0;
  localparam logic [2:0] CK_F2 = 3'h1;
  localparam logic [2:0] CK_F4 = 3'h2;
  localparam logic [2:0] CK_F8 = 3'h3;
  localparam logic [2:0] CK_F32 = 3'h4;
  localparam logic [2:0] CK_EXT = 3'h5;
  localparam logic [2:0] CK_OSC = 3'h6;
  localparam logic [15:0] GR_RST = 16'hffff;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARMED = 2'h1,
    ST_COUNT = 2'h3
  } wopt_state_t;
endpackage

// ---- src/wopt_timer.sv ----
// Wait one-shot PWM timer with APB register access.
//
// Decided for this implementation: register access over APB.
module wopt_timer (
  // Clock and reset.
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  // APB slave.
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Pins.
  input wire logic I_TRIG_IN,
  input wire logic I_EXT_COUNT_CLK,
  output logic O_PWM_OUT,
  output logic O_IRQ_REQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a[11:2] == idx);
  endfunction

  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic wr;
  logic [31:0] rdata_nxt;
  logic err_nxt;
  logic we_mode, we_c1, we_trig, we_ien, we_st, we_cnt;
  logic we_a, we_b, we_c, we_d;
  logic run_r, bfd_r;
  logic [7:0] c1_r;
  logic [2:0] trig_r;
  logic [wopt_pkg::NSRC-1:0] ien_r, st_r, st_set;
  logic irq_r;
  logic [15:0] cnt_r, gra_r, grb_r, grc_r, grd_r;
  logic out_r;
  wopt_pkg::wopt_state_t state_r;

  assign wr = I_PSEL & I_PENABLE & pready_r & I_PWRITE;
  assign we_mode = wr & hit(I_PADDR, wopt_pkg::IDX_MODE);
  assign we_c1 = wr & hit(I_PADDR, wopt_pkg::IDX_CTRL1);
  assign we_trig = wr & hit(I_PADDR, wopt_pkg::IDX_TRIG);
  assign we_ien = wr & hit(I_PADDR, wopt_pkg::IDX_IEN);
  assign we_st = wr & hit(I_PADDR, wopt_pkg::IDX_STAT);
  assign we_cnt = wr & hit(I_PADDR, wopt_pkg::IDX_CNT);
  assign we_a = wr & hit(I_PADDR, wopt_pkg::IDX_GRA);
  assign we_b = wr & hit(I_PADDR, wopt_pkg::IDX_GRB);
  assign we_c = wr & hit(I_PADDR, wopt_pkg::IDX_GRC);
  assign we_d = wr & hit(I_PADDR, wopt_pkg::IDX_GRD);

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait-free access phase, data captured at setup.

  always_comb begin
    rdata_nxt = 32'h0;
    err_nxt = 1'b0;
    if (hit(I_PADDR, wopt_pkg::IDX_MODE)) begin
      rdata_nxt[wopt_pkg::MODE_RUN] = run_r;
      rdata_nxt[wopt_pkg::MODE_BFD] = bfd_r;
    end else if (hit(I_PADDR, wopt_pkg::IDX_CTRL1)) begin
      rdata_nxt[7:0] = c1_r;
    end else if (hit(I_PADDR, wopt_pkg::IDX_TRIG)) begin
      rdata_nxt[2:0] = trig_r;
    end else if (hit(I_PADDR, wopt_pkg::IDX_IEN)) begin
      rdata_nxt[wopt_pkg::NSRC-1:0] = ien_r;
    end else if (hit(I_PADDR, wopt_pkg::IDX_STAT)) begin
      rdata_nxt[wopt_pkg::NSRC-1:0] = st_r;
    end else if (hit(I_PADDR, wopt_pkg::IDX_IRQC)) begin
      rdata_nxt[0] = irq_r;
    end else if (hit(I_PADDR, wopt_pkg::IDX_CNT)) begin
      rdata_nxt[15:0] = cnt_r;
    end else if (hit(I_PADDR, wopt_pkg::IDX_GRA)) begin
      rdata_nxt[15:0] = gra_r;
    end else if (hit(I_PADDR, wopt_pkg::IDX_GRB)) begin
      rdata_nxt[15:0] = grb_r;
    end else if (hit(I_PADDR, wopt_pkg::IDX_GRC)) begin
      rdata_nxt[15:0] = grc_r;
    end else if (hit(I_PADDR, wopt_pkg::IDX_GRD)) begin
      rdata_nxt[15:0] = grd_r;
    end else begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= I_PSEL & ~I_PENABLE;
      if (I_PSEL & ~I_PENABLE) begin
        prdata_r <= I_PWRITE ? 32'h0 : rdata_nxt;
        pslverr_r <= err_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, edge detection and count source.
  // Only the second and third stages feed the edge detectors.

  logic [2:0] trg_s_r, eck_s_r;
  logic [4:0] presc_r;
  logic trg_rise, trg_fall, trg_edge, eck_rise, tick;
  logic [1:0] edsel;

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      trg_s_r <= 3'h0;
      eck_s_r <= 3'h0;
      presc_r <= 5'h0;
    end else begin
      trg_s_r <= {trg_s_r[1:0], I_TRIG_IN};
      eck_s_r <= {eck_s_r[1:0], I_EXT_COUNT_CLK};
      presc_r <= presc_r + 5'h1;
    end
  end

  assign edsel = trig_r[wopt_pkg::TRG_EDHI:wopt_pkg::TRG_EDLO];
  assign trg_rise = trg_s_r[1] & ~trg_s_r[2];
  assign trg_fall = ~trg_s_r[1] & trg_s_r[2];
  assign eck_rise = eck_s_r[1] & ~eck_s_r[2];

  always_comb begin
    case (edsel)
      wopt_pkg::EDGE_OFF: trg_edge = 1'b0;
      wopt_pkg::EDGE_RISE: trg_edge = trg_rise;
      wopt_pkg::EDGE_FALL: trg_edge = trg_fall;
      default: trg_edge = trg_rise | trg_fall;
    endcase
  end

  always_comb begin
    case (c1_r[wopt_pkg::C1_CKHI:wopt_pkg::C1_CKLO])
      wopt_pkg::CK_F1: tick = 1'b1;
      wopt_pkg::CK_F2: tick = presc_r[0];
      wopt_pkg::CK_F4: tick = &presc_r[1:0];
      wopt_pkg::CK_F8: tick = &presc_r[2:0];
      wopt_pkg::CK_F32: tick = &presc_r;
      wopt_pkg::CK_EXT: tick = eck_rise;
      // The fast oscillator runs at the system clock rate in this block.
      wopt_pkg::CK_OSC: tick = 1'b1;
      default: tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare events.

  logic adv, m_a, m_b, m_c, m_d, ovf, clr_sel, stop_sel, sel_b, immed, trg_go;

  assign adv = (state_r == wopt_pkg::ST_COUNT) & tick;
  assign m_a = adv & (cnt_r == gra_r);
  assign m_b = adv & (cnt_r == grb_r);
  assign m_c = adv & (cnt_r == grc_r);
  assign m_d = adv & (cnt_r == grd_r);
  assign ovf = adv & (cnt_r == wopt_pkg::CNT_MAX);
  assign clr_sel = c1_r[wopt_pkg::C1_CLEAR_ON_PERIOD_SEL];
  assign stop_sel = trig_r[wopt_pkg::TRG_STOP];
  assign sel_b = c1_r[wopt_pkg::C1_OUTB];
  assign immed = (edsel == wopt_pkg::EDGE_OFF) | ~stop_sel;
  // A trigger is honoured only while armed; edges during a count are ignored.
  assign trg_go = (state_r == wopt_pkg::ST_ARMED) & trg_edge;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      c1_r <= wopt_pkg::C1_RST;
      trig_r <= 3'h0;
      ien_r <= '0;
      bfd_r <= 1'b0;
    end else begin
      if (we_c1) c1_r <= I_PWDATA[7:0];
      if (we_trig) trig_r <= I_PWDATA[2:0];
      if (we_ien) ien_r <= I_PWDATA[wopt_pkg::NSRC-1:0];
      if (we_mode) bfd_r <= I_PWDATA[wopt_pkg::MODE_BFD];
    end
  end

  // Mode register write takes precedence over a coinciding period stop.
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      state_r <= wopt_pkg::ST_IDLE;
      run_r <= 1'b0;
    end else if (we_mode) begin
      run_r <= I_PWDATA[wopt_pkg::MODE_RUN];
      if (!I_PWDATA[wopt_pkg::MODE_RUN]) begin
        state_r <= wopt_pkg::ST_IDLE;
      end else if (state_r != wopt_pkg::ST_COUNT) begin
        state_r <= immed ? wopt_pkg::ST_COUNT : wopt_pkg::ST_ARMED;
      end
    end else if (m_a & stop_sel) begin
      state_r <= wopt_pkg::ST_IDLE;
      run_r <= 1'b0;
    end else if (trg_go) begin
      state_r <= wopt_pkg::ST_COUNT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and compare registers.
  // A software stop still takes the tick of its own edge; the count is frozen after it.

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      cnt_r <= 16'h0;
    end else if (m_a & clr_sel) begin
      cnt_r <= 16'h0;
    end else if (we_cnt) begin
      cnt_r <= I_PWDATA[15:0];
    end else if (trg_go) begin
      cnt_r <= 16'h0;
    end else if (adv) begin
      cnt_r <= cnt_r + 16'h1;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      gra_r <= wopt_pkg::GR_RST;
      grb_r <= wopt_pkg::GR_RST;
      grc_r <= wopt_pkg::GR_RST;
      grd_r <= wopt_pkg::GR_RST;
    end else begin
      if (we_a) gra_r <= I_PWDATA[15:0];
      if (we_b) begin
        grb_r <= I_PWDATA[15:0];
      end else if (bfd_r & m_a) begin
        grb_r <= grd_r;
      end
      if (we_c) grc_r <= I_PWDATA[15:0];
      if (we_d) grd_r <= I_PWDATA[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pin.

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      out_r <= 1'b0;
    end else if (we_c1) begin
      out_r <= I_PWDATA[wopt_pkg::C1_OUTB];
    end else if (we_mode & ~I_PWDATA[wopt_pkg::MODE_RUN]) begin
      out_r <= sel_b;
    end else if (m_a & stop_sel) begin
      out_r <= sel_b;
    end else if (m_b) begin
      out_r <= sel_b;
    end else if (m_c) begin
      out_r <= ~sel_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, enable and merged request; a hardware set beats a clear.

  assign st_set = {ovf, m_d, m_c, m_b, m_a};

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      st_r <= '0;
      irq_r <= 1'b0;
    end else begin
      st_r <= (we_st ? (st_r & I_PWDATA[wopt_pkg::NSRC-1:0]) : st_r) | st_set;
      irq_r <= |(st_r & ien_r);
    end
  end

  assign O_PRDATA = prdata_r;
  assign O_PREADY = pready_r;
  assign O_PSLVERR = pslverr_r;
  assign O_PWM_OUT = out_r;
  assign O_IRQ_REQ = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);

  run_stop_a:
    assert property (we_mode & ~I_PWDATA[wopt_pkg::MODE_RUN] & ~we_c1 |=>
      state_r == wopt_pkg::ST_IDLE && O_PWM_OUT == sel_b ##1 $stable(cnt_r))
    else $error("stop did not restore level or hold count");
  ctrl_level_a:
    assert property (we_c1 |=> O_PWM_OUT == c1_r[wopt_pkg::C1_OUTB])
    else $error("control write did not drive initial level");
  wait_active_a:
    assert property (m_c & ~m_b & ~(m_a & stop_sel) & ~wr |=> O_PWM_OUT == ~sel_b)
    else $error("wait match did not activate output");
  end_inactive_a:
    assert property (m_b & ~wr |=> O_PWM_OUT == sel_b)
    else $error("change match did not end active level");
  period_clear_a:
    assert property (m_a & clr_sel |=> cnt_r == 16'h0)
    else $error("period match did not clear counter");
  match_stop_a:
    assert property (m_a & stop_sel & ~we_mode |=> state_r == wopt_pkg::ST_IDLE && !run_r)
    else $error("period match did not stop count");
  overflow_wrap_a:
    assert property (ovf & ~(m_a & clr_sel) & ~we_cnt |=> cnt_r == 16'h0 && st_r[wopt_pkg::ST_OVF])
    else $error("overflow did not wrap and flag");
  irq_level_a:
    assert property (|(st_r & ien_r) |=> O_IRQ_REQ ##0 1'b1)
    else $error("request flag missing");
  irq_drop_a:
    assert property (!(|(st_r & ien_r)) |=> !O_IRQ_REQ)
    else $error("request flag held without source");
  trig_start_a:
    assert property (trg_go & ~we_mode & ~we_cnt |=>
      state_r == wopt_pkg::ST_COUNT && cnt_r == 16'h0)
    else $error("trigger did not start count");
  status_hold_a:
    assert property (st_r[wopt_pkg::ST_OVF] & ~we_st |=> st_r[wopt_pkg::ST_OVF] [*1])
    else $error("status cleared without write");
  immed_start_a:
    assert property (we_mode & I_PWDATA[wopt_pkg::MODE_RUN] & immed |=>
      state_r == wopt_pkg::ST_COUNT)
    else $error("run write did not start count at once");
  status_set_a:
    assert property (m_a |=> st_r[wopt_pkg::ST_A])
    else $error("period match did not set its status");
  buffer_load_a:
    assert property (bfd_r & m_a & ~we_b |=> grb_r == $past(grd_r))
    else $error("buffered change point not loaded");
  free_run_a:
    assert property (m_a & ~clr_sel & ~we_cnt & (cnt_r != wopt_pkg::CNT_MAX) |=>
      cnt_r == $past(cnt_r) + 16'h1)
    else $error("free-running counter did not pass period");
  idle_hold_a:
    assert property ((state_r == wopt_pkg::ST_IDLE) & ~we_cnt |=> cnt_r == $past(cnt_r))
    else $error("stopped counter changed");
  trig_cov: cover property (trg_go ##[1:1000] m_c);
  buf_cov: cover property (bfd_r & m_a);
  soft_stop_cov: cover property (we_mode & ~I_PWDATA[wopt_pkg::MODE_RUN] & adv);
  stop_cov: cover property (m_a & stop_sel);
  ovf_cov: cover property (ovf);

endmodule // wopt_timer

// ---- testbench/wopt_far_side.sv ----
// Trigger source, external count clock and pulse-measuring load of the timer.
module wopt_far_side (
  // Clock and bench control.
  input wire logic i_clk,
  input wire logic i_clr,
  input wire logic i_act_lo,
  input wire logic i_trig_level,
  input wire logic i_ext_en,
  // Timer side.
  input wire logic i_pwm,
  output logic o_trig,
  output logic o_ext_clk,
  output int o_pulses,
  output int o_width,
  output int o_period
);
  timeunit 1ns;
  timeprecision 1ps;
  logic trig_r;
  logic ext_r;
  logic act_q;
  logic [1:0] div_r;
  int run_len;
  int since_rise;
  wire act = i_pwm ^ i_act_lo;
  assign o_trig = trig_r;
  assign o_ext_clk = ext_r;
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    trig_r <= i_trig_level;
    div_r <= i_clr ? 2'h0 : div_r + 2'h1;
    // The count clock has a period of four cycles and stands still when unused.
    ext_r <= i_ext_en & (div_r[0] ? ~ext_r : ext_r);
    act_q <= act;
    if (i_clr) begin
      o_pulses <= 0;
      o_width <= 0;
      o_period <= 0;
      run_len <= 0;
      since_rise <= 0;
    end else begin
      since_rise <= since_rise + 1;
      if (act) run_len <= run_len + 1;
      if (act && !act_q) begin
        o_pulses <= o_pulses + 1;
        o_period <= since_rise;
        since_rise <= 1;
        run_len <= 1;
      end
      if (!act && act_q) o_width <= run_len;
    end
  end
endmodule // wopt_far_side

// ---- testbench/tb_wait_oneshot_pwm_timer.sv ----
// Self-checking testbench of the wait one-shot PWM timer.
module tb_wait_oneshot_pwm_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, pen, pwr, prdy, perr, trig, ext, pwm, irq, errv;
  logic clr, act_lo, tlev, ext_en;
  logic [11:0] paddr;
  logic [31:0] pwd, prd, rdv, seed, c1;
  logic [15:0] p, n, m;
  int pulses, width, period, mismatches, checks_done, k, c;
  int divs[7] = '{1, 2, 4, 8, 32, 4, 1};
  wopt_timer uut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy),
    .O_PSLVERR(perr), .I_TRIG_IN(trig), .I_EXT_COUNT_CLK(ext), .O_PWM_OUT(pwm),
    .O_IRQ_REQ(irq));
  wopt_far_side far (.i_clk(clk), .i_clr(clr), .i_act_lo(act_lo), .i_trig_level(tlev),
    .i_ext_en(ext_en), .i_pwm(pwm), .o_trig(trig), .o_ext_clk(ext), .o_pulses(pulses),
    .o_width(width), .o_period(period));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd(input int lim);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return 16'(seed % 32'(lim));
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr_en, input logic [9:0] idx, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr_en;
    paddr <= {idx, 2'h0};
    pwd <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (prdy !== 1'b1 && t < 50);
    if (t >= 50) mismatches++;
    rdv = prd;
    errv = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask
  task automatic rd(input logic [9:0] idx);
    apb(1'b0, idx, 32'h0);
  endtask
  task automatic tick(input int cyc);
    repeat (cyc) @(posedge clk);
  endtask
  task automatic wait_p(input int cnt);
    int t;
    t = 0;
    while (pulses < cnt && t < 20000) begin
      @(posedge clk);
      t++;
    end
    chk(32'(pulses >= cnt), 32'h1);
  endtask
  // Programs a random wait, change point and period while the timer is stopped.
  task automatic prog(input logic [7:0] ctl, input logic [7:0] trg);
    p = 16'h1 + rnd(8);
    n = p + 16'h2 + rnd(8);
    m = n + 16'h1 + rnd(6);
    wr(wopt_pkg::IDX_GRA, 32'(m));
    wr(wopt_pkg::IDX_GRB, 32'(n));
    wr(wopt_pkg::IDX_GRC, 32'(p));
    wr(wopt_pkg::IDX_CNT, 32'h0);
    wr(wopt_pkg::IDX_CTRL1, 32'(ctl));
    wr(wopt_pkg::IDX_TRIG, 32'(trg));
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, pen, pwr, act_lo, tlev, ext_en} = '0;
    {paddr, pwd} = '0;
    {rst, clr} = 2'h3;
    seed = 32'h0001255a;
    mismatches = 0;
    checks_done = 0;
    tick(3);
    rst <= 1'b0;
    clr <= 1'b0;
    rd(wopt_pkg::IDX_CTRL1);
    chk(rdv, 32'(wopt_pkg::C1_RST));
    rd(wopt_pkg::IDX_GRA);
    chk(rdv, 32'(wopt_pkg::GR_RST));
    rd(10'h3ff);
    chk(32'(errv), 32'h1);
    wr(wopt_pkg::IDX_CTRL1, 32'h0d);
    tick(2);
    chk(32'(pwm), 32'h0);
    wr(wopt_pkg::IDX_CTRL1, 32'h02);
    tick(2);
    chk(32'(pwm), 32'h1);
    $display("Test of reset values and levels done");
    for (c = 0; c < 7; c++) begin
      ext_en <= (c == 5);
      prog(8'h80 | 8'(c << 4), 8'(c % 4));
      wr(wopt_pkg::IDX_MODE, 32'h1);
      k = 0;
      while (pwm !== 1'b1 && k < 2000) begin
        @(posedge clk);
        k++;
      end
      if (c == 0) chk(32'(k >= p + 1 && k <= p + 3), 32'h1);
      wait_p(3);
      chk(32'(width), 32'((n - p) * divs[c]));
      chk(32'(period), 32'((m + 1) * divs[c]));
      wr(wopt_pkg::IDX_MODE, 32'h0);
    end
    $display("Test of count sources done");
    act_lo <= 1'b1;
    prog(8'h82, 8'h00);
    wr(wopt_pkg::IDX_GRB, 32'h40);
    wr(wopt_pkg::IDX_MODE, 32'h1);
    wait_p(1);
    wr(wopt_pkg::IDX_MODE, 32'h0);
    tick(2);
    chk(32'(pwm), 32'h1);
    rd(wopt_pkg::IDX_CNT);
    c1 = rdv;
    tick(5);
    rd(wopt_pkg::IDX_CNT);
    chk(rdv, c1);
    $display("Test of stop by software done");
    act_lo <= 1'b0;
    for (c = 1; c < 4; c++) begin
      tlev <= (c == 2);
      prog(8'h80, 8'(4 + c));
      wr(wopt_pkg::IDX_MODE, 32'h1);
      tick(20);
      chk(32'(pulses), 32'h0);
      tlev <= (c != 2);
      wait_p(1);
      tick(int'(m) + 40);
      chk(32'(pulses), 32'h1);
      chk(32'(width), 32'(n - p));
      chk(32'(pwm), 32'h0);
      rd(wopt_pkg::IDX_MODE);
      chk(32'(rdv[0]), 32'h0);
    end
    wr(wopt_pkg::IDX_MODE, 32'h1);
    tlev <= 1'b0;
    wait_p(2);
    tick(int'(m) + 40);
    $display("Test of trigger edges done");
    wr(wopt_pkg::IDX_STAT, 32'h0);
    wr(wopt_pkg::IDX_IEN, 32'h0);
    prog(8'h80, 8'h00);
    wr(wopt_pkg::IDX_MODE, 32'h1);
    wait_p(2);
    wr(wopt_pkg::IDX_MODE, 32'h0);
    rd(wopt_pkg::IDX_STAT);
    chk(32'(rdv[2:0]), 32'h7);
    chk(32'(irq), 32'h0);
    wr(wopt_pkg::IDX_IEN, 32'h02);
    tick(2);
    chk(32'(irq), 32'h1);
    wr(wopt_pkg::IDX_IEN, 32'h06);
    tick(2);
    chk(32'(irq), 32'h1);
    rd(wopt_pkg::IDX_STAT);
    chk(32'(rdv[2:0]), 32'h7);
    wr(wopt_pkg::IDX_STAT, 32'h1d);
    tick(2);
    chk(32'(irq), 32'h1);
    wr(wopt_pkg::IDX_STAT, 32'h19);
    tick(2);
    chk(32'(irq), 32'h0);
    rd(wopt_pkg::IDX_IRQC);
    chk(32'(rdv[0]), 32'h0);
    $display("Test of interrupt merging done");
    wr(wopt_pkg::IDX_STAT, 32'h0);
    wr(wopt_pkg::IDX_IEN, 32'h10);
    wr(wopt_pkg::IDX_GRA, 32'h10);
    wr(wopt_pkg::IDX_CTRL1, 32'h0);
    wr(wopt_pkg::IDX_CNT, 32'hfff0);
    wr(wopt_pkg::IDX_MODE, 32'h1);
    tick(40);
    wr(wopt_pkg::IDX_MODE, 32'h0);
    rd(wopt_pkg::IDX_STAT);
    chk(32'(rdv[4]), 32'h1);
    chk(32'(irq), 32'h1);
    rd(wopt_pkg::IDX_CNT);
    chk(32'(rdv[15:0] > 16'h10 && rdv[15:0] < 16'h30), 32'h1);
    $display("Test of overflow done");
    wr(wopt_pkg::IDX_STAT, 32'h0);
    prog(8'h80, 8'h00);
    wr(wopt_pkg::IDX_GRD, 32'(n - 16'h1));
    wr(wopt_pkg::IDX_MODE, 32'h3);
    wait_p(3);
    chk(32'(width), 32'(n - p - 16'h1));
    wr(wopt_pkg::IDX_MODE, 32'h0);
    rd(wopt_pkg::IDX_GRB);
    chk(rdv, 32'(n - 16'h1));
    rd(wopt_pkg::IDX_STAT);
    chk(32'(rdv[3]), 32'h1);
    $display("Test of change point buffer done");
    print_verdict();
  end
endmodule // tb_wait_oneshot_pwm_timer
